// ### dam_cmp.sv
`timescale 1ns/1ps
`default_nettype none

module dam_cmp #(
  parameter int W = 32
) (
  // Comparison operands and results
  dam_cmp_if.cmp c
);

  // Two guard bits keep centre plus offset from wrapping
  function automatic logic signed [W+1:0] ext(input logic signed [W-1:0] v);
    ext = {{2{v[W-1]}}, v};
  endfunction

  logic signed [W+1:0] val;
  logic signed [W+1:0] hi_pt;
  logic signed [W+1:0] lo_pt;
  logic signed [W+1:0] hy;

  assign val = ext(c.value);
  assign hi_pt = ext(c.centre) + ext(c.hi_ofs);
  assign lo_pt = ext(c.centre) + ext(c.lo_ofs);
  assign hy = $signed({3'b000, c.hyst});

  assign c.hi_trip = val > hi_pt;
  assign c.lo_trip = val < lo_pt;
  // Alarm stays present until it is past the trip point by the hysteresis
  assign c.hi_hold = val > hi_pt - hy;
  assign c.lo_hold = val < lo_pt + hy;

endmodule // dam_cmp

`default_nettype wire

// ### dam_cmp_if.sv
`timescale 1ns/1ps
`default_nettype none

interface dam_cmp_if #(parameter int W = 32);
  logic signed [W-1:0] value;
  logic signed [W-1:0] centre;
  logic signed [W-1:0] hi_ofs;
  logic signed [W-1:0] lo_ofs;
  logic [W-2:0] hyst;
  logic hi_trip;
  logic hi_hold;
  logic lo_trip;
  logic lo_hold;
  modport cmp (input value, centre, hi_ofs, lo_ofs, hyst, output hi_trip, hi_hold, lo_trip, lo_hold);
  modport ctl (output value, centre, hi_ofs, lo_ofs, hyst, input hi_trip, hi_hold, lo_trip, lo_hold);
endinterface

`default_nettype wire

// ### dam_params.svh
`ifndef DAM_PARAMS_SVH
`define DAM_PARAMS_SVH

// Register byte offsets
`define DAM_ADR_CTRL 8'h00
`define DAM_ADR_HYST 8'h04
`define DAM_ADR_LOW_OFS 8'h08
`define DAM_ADR_HIGH_OFS 8'h0C
`define DAM_ADR_DELAY 8'h10
`define DAM_ADR_CMD 8'h14
`define DAM_ADR_STATUS 8'h18

// Control field positions
`define DAM_CTRL_TYPE 0
`define DAM_CTRL_SIDES_LSB 1
`define DAM_CTRL_SILENCE_EN 3
`define DAM_CTRL_LATCH 4
`define DAM_CTRL_BLK_LSB 5
`define DAM_CTRL_DISP 7
`define DAM_CTRL_OPEN 8

// Command bits
`define DAM_CMD_CLEAR 0
`define DAM_CMD_SILENCE 1

// Reset values
`define DAM_RST_CTRL 32'h0000_0001
`define DAM_RST_HYST 32'h0000_0001
`define DAM_RST_OFS 32'h0000_0000
`define DAM_RST_DELAY 14'h0000

// Timing
`define DAM_CLK_HZ 100_000_000
`define DAM_TICK_S 1
`define DAM_TICK_CYCLES (`DAM_TICK_S * `DAM_CLK_HZ)
`define DAM_DELAY_MAX 9999

`endif

// ### dam_pkg.sv
`default_nettype none

package dam_pkg;

  typedef enum logic [1:0] {DAM_SIDE_BOTH, DAM_SIDE_HIGH, DAM_SIDE_LOW} dam_sides_type;

  typedef enum logic [1:0] {DAM_BLK_OFF, DAM_BLK_STARTUP, DAM_BLK_SETPT, DAM_BLK_BOTH} dam_block_type;

  typedef enum logic [1:0] {DAM_ST_NONE, DAM_ST_HIGH, DAM_ST_LOW, DAM_ST_ERROR} dam_state_type;

endpackage

`default_nettype wire

// ### dam_src_model.sv
`timescale 1ns/1ps
`default_nettype none

module dam_src_model #(
  parameter int W = 32
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Requests from the bench
  input wire logic signed [W-1:0] val_req_i,
  input wire logic signed [W-1:0] centre_req_i,
  input wire logic err_req_i,
  // Source side
  output logic sample_o,
  output logic signed [W-1:0] value_o,
  output logic signed [W-1:0] centre_o,
  output logic err_o
);
  logic div_ff;

  // Strobe every other cycle, so a value held fewer than three cycles can be seen on a single sample only
  always_ff @(posedge clk_i) begin
    if (rst_i)
      div_ff <= 1'b0;
    else
      div_ff <= ~div_ff;
  end

  always_ff @(posedge clk_i) begin
    sample_o <= div_ff & ~rst_i;
    value_o <= val_req_i;
    centre_o <= centre_req_i;
    err_o <= err_req_i;
  end
endmodule // dam_src_model

`default_nettype wire

// ### dam_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dam_params.svh"

module dam_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, silence, clr, dis, errq, smp, verr, ack, alarm, ind, errs;
  logic [3:0] sel;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic signed [31:0] vreq, creq, val, centre;
  dam_pkg::dam_state_type st;
  int errors, total_checks;

  always #5 clk_i = ~clk_i;

  dam_src_model i_dam_src_model (.clk_i(clk_i), .rst_i(rst_i), .val_req_i(vreq), .centre_req_i(creq),
    .err_req_i(errq), .sample_o(smp), .value_o(val), .centre_o(centre), .err_o(verr));

  // Short tick keeps the delay tests brief
  dam_top #(.TICK_CYCLES(10)) i_dam_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sample_i(smp), .value_i(val), .value_err_i(verr), .centre_value_i(centre), .silence_strobe_i(silence),
    .clear_strobe_i(clr), .disable_i(dis), .alarm_o(alarm), .alarm_state_o(st), .indicate_o(ind),
    .err_status_o(errs));

  task stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Request stands until the rising edge that samples ack high; data is taken there
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50)
      errors++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), q, exp);
  endtask

  task ctl(input logic [31:0] d);
    wb(1'b1, `DAM_ADR_CTRL, d);
  endtask

  task drv(input logic [31:0] v, input int n = 6);
    @(posedge clk_i);
    vreq <= v;
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task pls(input logic c, input logic s);
    @(posedge clk_i);
    clr <= c;
    silence <= s;
    @(posedge clk_i);
    clr <= 1'b0;
    silence <= 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // Looks half a cycle after the last edge, never in the edge's own time step
  task see(input dam_pkg::dam_state_type s, input logic a);
    @(negedge clk_i);
    chk("state", st, s);
    chk("alarm", alarm, a);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    stop_test;
  end

  initial begin
    {cyc, stb, we, silence, clr, dis, errq} = 7'h00;
    sel = 4'h0;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    vreq = 32'h0000_0100;
    creq = 32'h0000_0100;
    errors = 0;
    total_checks = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`DAM_ADR_CTRL, `DAM_RST_CTRL);
    rd(`DAM_ADR_HYST, `DAM_RST_HYST);
    rd(`DAM_ADR_HIGH_OFS, `DAM_RST_OFS);
    rd(8'h20, 32'h0000_0000);
    see(dam_pkg::DAM_ST_NONE, 1'b0);
    wb(1'b1, `DAM_ADR_DELAY, 32'h0000_270F);
    rd(`DAM_ADR_DELAY, 32'h0000_270F);
    wb(1'b1, `DAM_ADR_DELAY, 32'h0000_0000);
    wb(1'b1, `DAM_ADR_HYST, 32'h0000_0004);
    wb(1'b1, `DAM_ADR_HIGH_OFS, 32'h0000_0010);
    wb(1'b1, `DAM_ADR_LOW_OFS, 32'hFFFF_FFF0);
    ctl(32'h0000_0081);
    drv(32'h0000_0110);
    see(dam_pkg::DAM_ST_NONE, 1'b0);
    drv(32'h0000_0111);
    see(dam_pkg::DAM_ST_HIGH, 1'b1);
    chk("ind", ind, 1'b1);
    drv(32'h0000_010E);
    see(dam_pkg::DAM_ST_HIGH, 1'b1);
    drv(32'h0000_0108);
    see(dam_pkg::DAM_ST_NONE, 1'b0);
    drv(32'h0000_00F0);
    see(dam_pkg::DAM_ST_NONE, 1'b0);
    drv(32'h0000_00EF);
    see(dam_pkg::DAM_ST_LOW, 1'b1);
    drv(32'h0000_00F2);
    see(dam_pkg::DAM_ST_LOW, 1'b1);
    drv(32'h0000_00F8);
    see(dam_pkg::DAM_ST_NONE, 1'b0);
    ctl(32'h0000_0083);
    drv(32'h0000_0000);
    see(dam_pkg::DAM_ST_NONE, 1'b0);
    drv(32'h0000_0100);
    ctl(32'h0000_0085);
    drv(32'h0000_0200);
    see(dam_pkg::DAM_ST_NONE, 1'b0);
    drv(32'h0000_0000);
    see(dam_pkg::DAM_ST_LOW, 1'b1);
    drv(32'h0000_0100);
    ctl(32'h0000_0001);
    drv(32'h0000_0200);
    chk("ind", ind, 1'b0);
    drv(32'h0000_0100);
    ctl(32'h0000_0181);
    see(dam_pkg::DAM_ST_NONE, 1'b1);
    drv(32'h0000_0200);
    see(dam_pkg::DAM_ST_HIGH, 1'b0);
    drv(32'h0000_0100);
    ctl(32'h0000_0091);
    drv(32'h0000_0200);
    drv(32'h0000_0100);
    see(dam_pkg::DAM_ST_HIGH, 1'b1);
    drv(32'h0000_0200);
    pls(1'b1, 1'b0);
    see(dam_pkg::DAM_ST_HIGH, 1'b1);
    drv(32'h0000_0100);
    wb(1'b1, `DAM_ADR_CMD, 32'h0000_0001);
    see(dam_pkg::DAM_ST_NONE, 1'b0);
    drv(32'h0000_0200);
    drv(32'h0000_0100);
    pls(1'b1, 1'b0);
    see(dam_pkg::DAM_ST_NONE, 1'b0);
    ctl(32'h0000_0099);
    drv(32'h0000_0200);
    pls(1'b0, 1'b1);
    see(dam_pkg::DAM_ST_HIGH, 1'b0);
    drv(32'h0000_0100);
    pls(1'b1, 1'b0);
    drv(32'h0000_0200);
    see(dam_pkg::DAM_ST_HIGH, 1'b1);
    wb(1'b1, `DAM_ADR_CMD, 32'h0000_0002);
    see(dam_pkg::DAM_ST_HIGH, 1'b0);
    // High state, silenced, timer pending, display lit, output quiet
    rd(`DAM_ADR_STATUS, 32'h0000_1540);
    drv(32'h0000_0100);
    pls(1'b1, 1'b0);
    ctl(32'h0000_0091);
    drv(32'h0000_0200);
    pls(1'b0, 1'b1);
    see(dam_pkg::DAM_ST_HIGH, 1'b1);
    drv(32'h0000_0100);
    pls(1'b1, 1'b0);
    ctl(32'h0000_0081);
    @(posedge clk_i);
    dis <= 1'b1;
    drv(32'h0000_0200);
    see(dam_pkg::DAM_ST_NONE, 1'b0);
    drv(32'h0000_0100);
    @(posedge clk_i);
    dis <= 1'b0;
    ctl(32'h0000_0080);
    drv(32'h0000_0200);
    see(dam_pkg::DAM_ST_NONE, 1'b0);
    drv(32'h0000_0100);
    ctl(32'h0000_0081);
    errq <= 1'b1;
    drv(32'h0000_0100);
    see(dam_pkg::DAM_ST_ERROR, 1'b1);
    chk("err", errs, 1'b0);
    @(posedge clk_i);
    errq <= 1'b0;
    drv(32'h0000_0100);
    // Three seconds are thirty cycles; twenty cycles never hold three ticks
    wb(1'b1, `DAM_ADR_DELAY, 32'h0000_0003);
    drv(32'h0000_0200, 18);
    see(dam_pkg::DAM_ST_NONE, 1'b0);
    drv(32'h0000_0100, 10);
    drv(32'h0000_0200, 18);
    see(dam_pkg::DAM_ST_NONE, 1'b0);
    drv(32'h0000_0200, 40);
    see(dam_pkg::DAM_ST_HIGH, 1'b1);
    drv(32'h0000_0100);
    wb(1'b1, `DAM_ADR_DELAY, 32'h0000_0000);
    ctl(32'h0000_0041);
    @(posedge clk_i);
    creq <= 32'h0000_0180;
    drv(32'h0000_0200);
    see(dam_pkg::DAM_ST_NONE, 1'b0);
    drv(32'h0000_0180);
    drv(32'h0000_0200);
    see(dam_pkg::DAM_ST_HIGH, 1'b1);
    chk("err", errs, 1'b0);
    // Reset in mid-run, with an alarm standing
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    see(dam_pkg::DAM_ST_NONE, 1'b0);
    rd(`DAM_ADR_CTRL, `DAM_RST_CTRL);
    stop_test;
  end
endmodule // dam_tb_top

`default_nettype wire

// ### dam_tick.sv
`timescale 1ns/1ps
`default_nettype none

module dam_tick #(
  parameter int unsigned CYCLES = 100
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Time base
  output logic tick_o
);

  logic [31:0] cnt_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 32'h0000_0000;
    end else if (cnt_ff == CYCLES - 1) begin
      cnt_ff <= 32'h0000_0000;
    end else begin
      cnt_ff <= cnt_ff + 32'h0000_0001;
    end
  end

  assign tick_o = (cnt_ff == CYCLES - 1);

  property p_tick_period;
    @(posedge clk_i) disable iff (rst_i) tick_o |=> !tick_o || (CYCLES == 1);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick repeated too early");

endmodule // dam_tick

`default_nettype wire

// ### dam_top.sv
// Behaviour
// - Sides picks high, low or both checks
// - Alarm clears only past trip by hysteresis
// - Silence drops output except on an error alarm, keeps alarm state
// - Silence by strobe or command when allowed
// - Latching alarm needs condition gone plus clear
// - Non-latching alarm clears when condition gone
// - Blocking suppresses alarms until normal range seen
// - Startup, set-point, both or off arm blocking; control resets with blocking off, so startup arming never takes effect
// - Display option drives flashing status indication; the code holds indicate_o steady while any alarm stands
// - Polarity: output on or off during alarm
// - Alarm only after condition held delay seconds
// - Return to normal abandons delay timer
// - Low condition: value below centre plus offset
// - High condition: value above centre plus offset
// - Input error raises error alarm, output active
// - Own error status always reports none
// - Type off holds output off, no alarms
// - Disable input acts as type off
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dam_params.svh"

module dam_top #(
  parameter int W = 32,
  parameter int DLY_W = 14,
  parameter int unsigned TICK_CYCLES = `DAM_TICK_CYCLES
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Monitored values
  input wire logic sample_i,
  input wire logic signed [W-1:0] value_i,
  input wire logic value_err_i,
  input wire logic signed [W-1:0] centre_value_i,
  // Receivers
  input wire logic silence_strobe_i,
  input wire logic clear_strobe_i,
  input wire logic disable_i,
  // Transmitter and status
  output logic alarm_o,
  output dam_pkg::dam_state_type alarm_state_o,
  output logic indicate_o,
  output logic err_status_o
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // Register file
  logic [31:0] ctrl_ff;
  logic [31:0] hyst_ff;
  logic [31:0] lo_ofs_ff;
  logic [31:0] hi_ofs_ff;
  logic [DLY_W-1:0] delay_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic wr;
  logic cmd_clear;
  logic cmd_silence;
  logic ofs_write;

  // Alarm state
  logic alm_hi_ff;
  logic alm_lo_ff;
  logic alm_err_ff;
  logic silenced_ff;
  logic blocked_ff;
  logic pending_ff;
  logic [DLY_W-1:0] dly_cnt_ff;
  logic hi_hold_ff;
  logic lo_hold_ff;
  logic err_in_ff;
  logic signed [W-1:0] centre_seen_ff;

  logic tick;
  logic off;
  logic sides_hi;
  logic sides_lo;
  logic hi_trip;
  logic lo_trip;
  logic trip;
  logic clr_req;
  logic silence_req;
  logic start_ff;
  logic alm_any;
  logic active;
  logic raise;
  logic arm;
  dam_pkg::dam_sides_type sides;
  dam_pkg::dam_block_type blk;

  dam_cmp_if #(.W(W)) cif ();

  dam_cmp #(.W(W)) u_cmp (
    .c(cif.cmp)
  );

  dam_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  assign cif.value = value_i;
  assign cif.centre = centre_value_i;
  assign cif.hi_ofs = W'(signed'(hi_ofs_ff));
  assign cif.lo_ofs = W'(signed'(lo_ofs_ff));
  assign cif.hyst = (W-1)'(hyst_ff);

  // Bus side: one wait state, ack drops the cycle after it was given
  // Writes land with ack, on the edge where the master sees it, so both agree on timing
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
  assign cmd_clear = wr && wb_adr_i == `DAM_ADR_CMD && wb_sel_i[0] && wb_dat_i[`DAM_CMD_CLEAR];
  assign cmd_silence = wr && wb_adr_i == `DAM_ADR_CMD && wb_sel_i[0] && wb_dat_i[`DAM_CMD_SILENCE];
  assign ofs_write = wr && (wb_adr_i == `DAM_ADR_LOW_OFS || wb_adr_i == `DAM_ADR_HIGH_OFS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= `DAM_RST_CTRL;
      hyst_ff <= `DAM_RST_HYST;
      lo_ofs_ff <= `DAM_RST_OFS;
      hi_ofs_ff <= `DAM_RST_OFS;
      delay_ff <= `DAM_RST_DELAY;
    end else if (wr) begin
      unique case (wb_adr_i)
        `DAM_ADR_CTRL: ctrl_ff <= merge(ctrl_ff, wb_dat_i, wb_sel_i);
        `DAM_ADR_HYST: hyst_ff <= merge(hyst_ff, wb_dat_i, wb_sel_i);
        `DAM_ADR_LOW_OFS: lo_ofs_ff <= merge(lo_ofs_ff, wb_dat_i, wb_sel_i);
        `DAM_ADR_HIGH_OFS: hi_ofs_ff <= merge(hi_ofs_ff, wb_dat_i, wb_sel_i);
        `DAM_ADR_DELAY: delay_ff <= DLY_W'(merge(32'(delay_ff), wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (wb_adr_i)
      `DAM_ADR_CTRL: nxt_rdat = ctrl_ff;
      `DAM_ADR_HYST: nxt_rdat = hyst_ff;
      `DAM_ADR_LOW_OFS: nxt_rdat = lo_ofs_ff;
      `DAM_ADR_HIGH_OFS: nxt_rdat = hi_ofs_ff;
      `DAM_ADR_DELAY: nxt_rdat = 32'(delay_ff);
      `DAM_ADR_STATUS: nxt_rdat = {16'h0000, 2'(DLY_W'(0)), err_status_o, indicate_o, alarm_o, pending_ff,
                                    blocked_ff, silenced_ff, 2'(alarm_state_o), 6'h00};
      default: nxt_rdat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_ff) begin
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // Configuration decode
  assign off = !ctrl_ff[`DAM_CTRL_TYPE] || disable_i;
  assign sides = dam_pkg::dam_sides_type'(ctrl_ff[`DAM_CTRL_SIDES_LSB +: 2]);
  assign blk = dam_pkg::dam_block_type'(ctrl_ff[`DAM_CTRL_BLK_LSB +: 2]);

  always_comb begin
    unique case (sides)
      dam_pkg::DAM_SIDE_HIGH: begin
        sides_hi = 1'b1;
        sides_lo = 1'b0;
      end
      dam_pkg::DAM_SIDE_LOW: begin
        sides_hi = 1'b0;
        sides_lo = 1'b1;
      end
      default: begin
        sides_hi = 1'b1;
        sides_lo = 1'b1;
      end
    endcase
  end

  assign hi_trip = sides_hi && cif.hi_trip;
  assign lo_trip = sides_lo && cif.lo_trip;
  assign trip = hi_trip || lo_trip;
  assign raise = sample_i && trip && !blocked_ff && dly_cnt_ff >= delay_ff;
  assign clr_req = clear_strobe_i || cmd_clear;
  assign alm_any = alm_hi_ff || alm_lo_ff || alm_err_ff;
  assign silence_req = ctrl_ff[`DAM_CTRL_SILENCE_EN] && (silence_strobe_i || cmd_silence);
  assign arm = ((blk == dam_pkg::DAM_BLK_SETPT || blk == dam_pkg::DAM_BLK_BOTH)
                && (ofs_write || centre_value_i != centre_seen_ff))
               || ((blk == dam_pkg::DAM_BLK_STARTUP || blk == dam_pkg::DAM_BLK_BOTH) && start_ff);

  // Sampled hold flags decide when a standing alarm may go
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_hold_ff <= 1'b0;
      lo_hold_ff <= 1'b0;
      err_in_ff <= 1'b0;
      centre_seen_ff <= '0;
    end else begin
      centre_seen_ff <= centre_value_i;
      if (sample_i) begin
        hi_hold_ff <= sides_hi && cif.hi_hold;
        lo_hold_ff <= sides_lo && cif.lo_hold;
        err_in_ff <= value_err_i;
      end
    end
  end

  // Qualification delay
  always_ff @(posedge clk_i) begin
    if (rst_i || off) begin
      pending_ff <= 1'b0;
      dly_cnt_ff <= '0;
    end else if (sample_i && (!trip || blocked_ff)) begin
      pending_ff <= 1'b0;
      dly_cnt_ff <= '0;
    end else begin
      if (sample_i) begin
        pending_ff <= 1'b1;
      end
      if (tick && pending_ff && dly_cnt_ff != '1) begin
        dly_cnt_ff <= dly_cnt_ff + DLY_W'(1);
      end
    end
  end

  // Blocking: arming wins over release in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blocked_ff <= 1'b0;
    end else if (arm) begin
      blocked_ff <= 1'b1;
    end else if (sample_i && !trip && !value_err_i) begin
      blocked_ff <= 1'b0;
    end
  end

  // Startup flag is set only in the first cycle after reset release, while control still reads blocking off, so it never arms
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_ff <= 1'b1;
    end else begin
      start_ff <= 1'b0;
    end
  end

  // Alarm flags: clearing first, then raising, so a new event wins
  always_ff @(posedge clk_i) begin
    if (rst_i || off) begin
      alm_hi_ff <= 1'b0;
      alm_lo_ff <= 1'b0;
      alm_err_ff <= 1'b0;
    end else begin
      if (ctrl_ff[`DAM_CTRL_LATCH]) begin
        if (clr_req && !hi_hold_ff) alm_hi_ff <= 1'b0;
        if (clr_req && !lo_hold_ff) alm_lo_ff <= 1'b0;
        if (clr_req && !err_in_ff) alm_err_ff <= 1'b0;
      end else begin
        if (!hi_hold_ff) alm_hi_ff <= 1'b0;
        if (!lo_hold_ff) alm_lo_ff <= 1'b0;
        if (!err_in_ff) alm_err_ff <= 1'b0;
      end
      if (raise && hi_trip) alm_hi_ff <= 1'b1;
      if (raise && lo_trip) alm_lo_ff <= 1'b1;
      if (sample_i && value_err_i) alm_err_ff <= 1'b1;
    end
  end

  // Silenced until the alarm is fully cleared
  always_ff @(posedge clk_i) begin
    if (rst_i || off || !alm_any) begin
      silenced_ff <= 1'b0;
    end else if (silence_req) begin
      silenced_ff <= 1'b1;
    end
  end

  // Outputs; an input error overrides silencing
  assign active = alm_err_ff || (alm_any && !silenced_ff);
  assign alarm_o = off ? 1'b0 : (active ^ ctrl_ff[`DAM_CTRL_OPEN]);
  assign indicate_o = ctrl_ff[`DAM_CTRL_DISP] && alm_any;
  assign err_status_o = 1'b0;
  assign alarm_state_o = alm_err_ff ? dam_pkg::DAM_ST_ERROR :
                         alm_hi_ff ? dam_pkg::DAM_ST_HIGH :
                         alm_lo_ff ? dam_pkg::DAM_ST_LOW : dam_pkg::DAM_ST_NONE;

  // Checks
  property p_off_quiet;
    @(posedge clk_i) disable iff (rst_i) disable_i |-> !alarm_o ##1 !alm_any;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("alarm while disabled");

  property p_sides;
    @(posedge clk_i) disable iff (rst_i) (sides == dam_pkg::DAM_SIDE_HIGH) |-> !lo_trip;
  endproperty
  a_sides: assert property (p_sides) else $error("low side evaluated in high-only mode");

  property p_hyst;
    @(posedge clk_i) disable iff (rst_i)
      $fell(alm_hi_ff) && !$past(off) |-> !$past(hi_hold_ff);
  endproperty
  a_hyst: assert property (p_hyst) else $error("high alarm cleared inside hysteresis");

  property p_silence;
    @(posedge clk_i) disable iff (rst_i)
      silenced_ff && !alm_err_ff && !off |-> alarm_o == ctrl_ff[`DAM_CTRL_OPEN];
  endproperty
  a_silence: assert property (p_silence) else $error("silenced output still active");

  property p_latch;
    @(posedge clk_i) disable iff (rst_i)
      $fell(alm_lo_ff) && $past(ctrl_ff[`DAM_CTRL_LATCH]) && !$past(off) |-> $past(clr_req);
  endproperty
  a_latch: assert property (p_latch) else $error("latched alarm cleared without request");

  property p_nonlatch;
    @(posedge clk_i) disable iff (rst_i)
      alm_hi_ff && !ctrl_ff[`DAM_CTRL_LATCH] && !hi_hold_ff && !raise |=> !alm_hi_ff;
  endproperty
  a_nonlatch: assert property (p_nonlatch) else $error("non-latching alarm did not clear");

  property p_block;
    @(posedge clk_i) disable iff (rst_i) $rose(alm_hi_ff) |-> !$past(blocked_ff);
  endproperty
  a_block: assert property (p_block) else $error("alarm raised while blocked");

  property p_delay;
    @(posedge clk_i) disable iff (rst_i)
      $rose(alm_hi_ff || alm_lo_ff) |-> $past(dly_cnt_ff) >= $past(delay_ff);
  endproperty
  a_delay: assert property (p_delay) else $error("alarm before delay expired");

  property p_abandon;
    @(posedge clk_i) disable iff (rst_i) sample_i && !trip |=> dly_cnt_ff == '0 && !pending_ff;
  endproperty
  a_abandon: assert property (p_abandon) else $error("delay timer kept after return");

  property p_error;
    @(posedge clk_i) disable iff (rst_i)
      sample_i && value_err_i && !off ##1 !off |-> alarm_state_o == dam_pkg::DAM_ST_ERROR && alarm_o != ctrl_ff[`DAM_CTRL_OPEN];
  endproperty
  a_error: assert property (p_error) else $error("input error not flagged");

  property p_display;
    @(posedge clk_i) disable iff (rst_i) indicate_o |-> ctrl_ff[`DAM_CTRL_DISP] && alarm_state_o != dam_pkg::DAM_ST_NONE;
  endproperty
  a_display: assert property (p_display) else $error("indication without display");

  c_raise: cover property (@(posedge clk_i) disable iff (rst_i) $rose(alm_hi_ff));
  c_silenced: cover property (@(posedge clk_i) disable iff (rst_i) $rose(silenced_ff));
  c_latched_clear: cover property (@(posedge clk_i) disable iff (rst_i) $fell(alm_lo_ff) && ctrl_ff[`DAM_CTRL_LATCH]);
  c_unblock: cover property (@(posedge clk_i) disable iff (rst_i) $fell(blocked_ff));

endmodule // dam_top

`default_nettype wire
